// ---- rtl/dbsm_top.v ----
// buffer storage manager: cpu register decode, buffer ram address and
// strobes, disk/host port priority, host req/ack dma, bus-free arbitration
// assumes all inputs but NRST synchronous to CLOCK and a static ram on the outputs
//
// Function
// R1: decode register offsets 50h-5Fh and 70h into register strobes
// R2: offsets 50h, 51h, 70h hold nothing, only route host bus or ram
// R3: drive memory select and write strobe for every ram access
// R4: disk port wins when disk and host request the ram together
// R5: buffer sizes 256 bytes to 64K, sixteen address bits
// R6: fourteen address outputs, four double as latch strobes or enables
// R7: arbitration request stays pending while the scsi bus is busy
// R8: bus free after three idle cycles, arbitrate four cycles later
// R9: cpu reads id byte and runs selection itself
// R10: req/ack host transfer halts at the stop pointer
// R11: minimum mode drives address bits 0 to 9 directly
// R12: extended minimum mode drives address bits 0 to 13 directly
// R13: maximum mode drives low byte, high byte from external latches
// R14: extended bit of address mode picks minimum or extended minimum
// R15: maximum mode chosen when buffer size exceeds direct reach
// R16: minimum mode with ten address bits after reset
// R17: strobe high byte cycle after change, or after an intervening disk cycle
// R18: pointers change by cpu write or auto increment per transfer
// R19: cpu should not rewrite high pointers during disk transfers
// R20: latches refresh whenever a pointer crosses 256 bytes
// R21: separate host and device latch output enables in maximum mode
// R22: disk requests at most once per two clock cycles
// R23: memory select should drive the ram output enable
// R24: disk request sampled, byte moved on the next cycle
// R25: direction bit selects write or read pointer for disk and host
// R26: host read raises req and drive enable, drops both on ack
// R27: stop pointer matched against masked pointer sets dma done
// R28: address outputs unused in the mode stay at fixed levels
// R29: host ram cycle waits while a disk cycle holds the ram
`timescale 1ns/100ps
`include "dbsm_regs.vh"
`default_nettype none
module dbsm_top (
  input wire CLOCK,
  input wire NRST,
  input wire CS,
  input wire ALE,
  input wire RD_N,
  input wire WR_N,
  input wire [7:0] AD_IN,
  output reg [7:0] AD_OUT,
  output reg AD_OE,
  input wire DISK_XFER_REQUEST_N,
  output reg [13:0] BUF_ADDR,
  output reg BUFFER_MEM_SELECT_N,
  output reg BUF_WRITE_N,
  output reg HOST_REQ,
  input wire HOST_ACK,
  output reg HOST_DRIVE_ENABLE_N,
  output reg HOST_RECEIVE_ENABLE_N,
  output reg DATA_LATCH_STROBE,
  input wire BUSY_IN,
  input wire SEL_IN,
  output reg BUSY_OUT,
  output reg SEL_OUT,
  output reg TARGET_EN_N,
  output reg INITIATOR_EN_N
);
  // ============================================================
  // reset release
  reg rst_meta, rst_n;
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // ============================================================
  // helpers
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction
  function [15:0] step;
    input [15:0] p;
    input [15:0] m;
    reg [15:0] q;
    begin
      q = p + 16'h0001;
      step = (p & ~m) | (q & m); // circular inside the buffer
    end
  endfunction
  // ============================================================
  // cpu interface
  reg [7:0] addr, hctrl, dctrl, bsize, amode;
  reg [15:0] buffer_read_pointer, buffer_write_pointer, sp;
  reg wr_q, rd_q, arb_req, ok_arb, cpu_pend, cpu_wr;
  reg [2:0] free_cnt, arb_cnt;
  wire wr_go = CS & ~WR_N & wr_q;
  wire rd_go = CS & ~RD_N & rd_q;
  wire dir = dctrl[`DBSM_DC_DIR];
  wire arbitrating = (arb_cnt == `DBSM_ARB_CYCLES);
  wire [3:0] code = (bsize[3:0] > `DBSM_MAX_CODE) ? `DBSM_MAX_CODE
    : bsize[3:0];
  wire [15:0] mask = ~(16'hFFFF << ({1'b0, code} + 5'h08)); // see R5
  wire ext = amode[`DBSM_AM_EXT]; // see R14
  wire max_mode = ext ? (code > `DBSM_EXT_TOP_CODE)
    : (code > `DBSM_MIN_TOP_CODE); // see R15
  wire all_rst = wr_go & hit(addr, `DBSM_RESET_CTRL)
    & AD_IN[`DBSM_RC_ALL];
  wire ptr_rst = wr_go & hit(addr, `DBSM_RESET_CTRL);
  reg [7:0] next_rdata;
  always @* begin
    case (addr) // see R1
      `DBSM_HOST_CTRL: next_rdata = {hctrl[7:6], BUSY_IN, hctrl[4:1],
        arbitrating & ~SEL_IN};
      `DBSM_DMA_CTRL: next_rdata = dctrl;
      `DBSM_BUF_SIZE: next_rdata = bsize;
      `DBSM_ADDR_MODE: next_rdata = amode;
      `DBSM_RAP_LO: next_rdata = buffer_read_pointer[7:0];
      `DBSM_RAP_HI: next_rdata = buffer_read_pointer[15:8];
      `DBSM_WAP_LO: next_rdata = buffer_write_pointer[7:0];
      `DBSM_WAP_HI: next_rdata = buffer_write_pointer[15:8];
      `DBSM_STOP_LO: next_rdata = sp[7:0];
      `DBSM_STOP_HI: next_rdata = sp[15:8];
      default: next_rdata = `DBSM_RST_BYTE; // see R2
    endcase
  end
  // ============================================================
  // ram slot arbitration
  localparam H_IDLE = 2'h0;
  localparam H_RAM = 2'h1;
  localparam H_REQ = 2'h2;
  localparam H_REL = 2'h3;
  reg [1:0] hstate;
  reg disk_pend, rap_hi_pend, wap_hi_pend;
  wire disk_cyc = disk_pend; // see R24
  wire strobe_cyc = max_mode & (rap_hi_pend | wap_hi_pend) & ~disk_cyc;
  // strobes take the slot before host and cpu, so the latch is fresh first
  wire host_ram = (hstate == H_RAM) & ~disk_cyc & ~strobe_cyc; // see R4, R29
  wire cpu_ram = cpu_pend & ~disk_cyc & ~strobe_cyc & ~(hstate == H_RAM);
  wire dma_go = (dir ? dctrl[`DBSM_DC_RLATCH] : dctrl[`DBSM_DC_WLATCH])
    & ~dctrl[`DBSM_DC_DONE];
  wire [15:0] host_ptr = dir ? buffer_read_pointer : buffer_write_pointer; // see R25
  wire match = ((sp & mask) == (host_ptr & mask)); // see R27
  wire ack_take = (hstate == H_REQ) & HOST_ACK;
  wire rap_inc = (disk_cyc & ~dir) | (ack_take & dir); // see R18
  wire wap_inc = (disk_cyc & dir) | (host_ram & ~dir);
  wire [15:0] rap_nx = step(buffer_read_pointer, mask);
  wire [15:0] wap_nx = step(buffer_write_pointer, mask);
  // ============================================================
  // registers
  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      addr <= `DBSM_RST_BYTE;
      hctrl <= `DBSM_RST_BYTE;
      dctrl <= `DBSM_RST_BYTE;
      bsize <= `DBSM_RST_BYTE; // see R16
      amode <= `DBSM_RST_BYTE;
      buffer_read_pointer <= `DBSM_RST_PTR;
      buffer_write_pointer <= `DBSM_RST_PTR;
      sp <= `DBSM_RST_PTR;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cpu_pend <= 1'b0;
      cpu_wr <= 1'b0;
      rap_hi_pend <= 1'b0;
      wap_hi_pend <= 1'b0;
    end else begin
      wr_q <= WR_N;
      rd_q <= RD_N;
      if (ALE) begin
        addr <= AD_IN;
      end
      if (all_rst) begin
        hctrl <= `DBSM_RST_BYTE;
        dctrl <= `DBSM_RST_BYTE;
        bsize <= `DBSM_RST_BYTE;
        amode <= `DBSM_RST_BYTE;
      end else if (wr_go) begin
        if (hit(addr, `DBSM_HOST_CTRL)) hctrl <= AD_IN;
        if (hit(addr, `DBSM_DMA_CTRL)) dctrl <= AD_IN;
        if (hit(addr, `DBSM_BUF_SIZE)) bsize <= AD_IN;
        if (hit(addr, `DBSM_ADDR_MODE)) amode <= AD_IN;
      end
      // done: a new stop pointer restarts; a match sets and wins
      if (!all_rst && wr_go && (hit(addr, `DBSM_STOP_LO)
          || hit(addr, `DBSM_STOP_HI))) begin
        dctrl[`DBSM_DC_DONE] <= 1'b0;
      end
      if (hstate == H_IDLE && match && !all_rst
          && (dir ? dctrl[`DBSM_DC_RLATCH] : dctrl[`DBSM_DC_WLATCH])) begin
        dctrl[`DBSM_DC_DONE] <= 1'b1; // see R10, R27
      end
      if (ptr_rst) begin
        buffer_read_pointer <= `DBSM_RST_PTR;
        buffer_write_pointer <= `DBSM_RST_PTR;
        sp <= `DBSM_RST_PTR;
      end else begin
        if (wr_go && hit(addr, `DBSM_RAP_LO)) buffer_read_pointer[7:0] <= AD_IN;
        else if (wr_go && hit(addr, `DBSM_RAP_HI)) buffer_read_pointer[15:8] <= AD_IN;
        else if (rap_inc) buffer_read_pointer <= rap_nx;
        if (wr_go && hit(addr, `DBSM_WAP_LO)) buffer_write_pointer[7:0] <= AD_IN;
        else if (wr_go && hit(addr, `DBSM_WAP_HI)) buffer_write_pointer[15:8] <= AD_IN;
        else if (wap_inc) buffer_write_pointer <= wap_nx;
        if (wr_go && hit(addr, `DBSM_STOP_LO)) sp[7:0] <= AD_IN;
        if (wr_go && hit(addr, `DBSM_STOP_HI)) sp[15:8] <= AD_IN;
      end
      // high byte change arms a latch strobe; rap has the slot first
      if ((wr_go && hit(addr, `DBSM_RAP_HI))
          || (rap_inc && rap_nx[15:8] != buffer_read_pointer[15:8])) begin
        rap_hi_pend <= 1'b1; // see R17, R20
      end else if (strobe_cyc || !max_mode) begin
        rap_hi_pend <= 1'b0;
      end
      if ((wr_go && hit(addr, `DBSM_WAP_HI))
          || (wap_inc && wap_nx[15:8] != buffer_write_pointer[15:8])) begin
        wap_hi_pend <= 1'b1; // see R17, R20
      end else if ((strobe_cyc && !rap_hi_pend) || !max_mode) begin
        wap_hi_pend <= 1'b0;
      end
      if ((wr_go || rd_go) && hit(addr, `DBSM_BUF_ACCESS)) begin
        cpu_pend <= 1'b1; // see R2
        cpu_wr <= wr_go;
      end else if (cpu_ram) begin
        cpu_pend <= 1'b0;
      end
    end
  end
  // ============================================================
  // host dma handshake
  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      hstate <= H_IDLE;
      disk_pend <= 1'b0;
    end else begin
      disk_pend <= ~DISK_XFER_REQUEST_N; // see R24
      case (hstate)
        H_IDLE: if (dma_go && !match) hstate <= dir ? H_RAM : H_REQ;
        H_RAM: if (host_ram) hstate <= dir ? H_REQ : H_REL;
        H_REQ: if (HOST_ACK) hstate <= dir ? H_REL : H_RAM; // see R26
        H_REL: if (!HOST_ACK) hstate <= H_IDLE;
        default: hstate <= H_IDLE;
      endcase
    end
  end
  // ============================================================
  // bus free detection and arbitration
  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      free_cnt <= 3'h0;
      arb_cnt <= 3'h0;
      arb_req <= 1'b0;
      ok_arb <= 1'b0;
    end else begin
      if (BUSY_IN || SEL_IN) free_cnt <= 3'h0;
      else if (free_cnt != `DBSM_FREE_CYCLES) free_cnt <= free_cnt + 3'h1;
      // request stays stacked until cpu takes the bus or resets
      if (all_rst || (wr_go && hit(addr, `DBSM_HOST_CTRL)
          && AD_IN[`DBSM_HC_BSY])) begin
        arb_req <= 1'b0;
      end else if (wr_go && hit(addr, `DBSM_HOST_CTRL)
          && AD_IN[`DBSM_HC_ARB]) begin
        arb_req <= 1'b1; // see R7
      end
      if (SEL_IN || !arb_req) begin
        ok_arb <= 1'b0;
        arb_cnt <= 3'h0;
      end else if (free_cnt == `DBSM_FREE_CYCLES) begin
        ok_arb <= 1'b1; // see R8
      end
      if (ok_arb && !SEL_IN && arb_req && !arbitrating) begin
        arb_cnt <= arb_cnt + 3'h1; // see R8
      end
    end
  end
  // ============================================================
  // registered outputs
  reg [15:0] acc_ptr;
  reg acc_host;
  always @* begin
    acc_host = host_ram | cpu_ram;
    if (disk_cyc) acc_ptr = dir ? buffer_write_pointer : buffer_read_pointer; // see R25
    else if (host_ram) acc_ptr = host_ptr;
    else acc_ptr = dir ? buffer_write_pointer : buffer_read_pointer;
  end
  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      AD_OUT <= `DBSM_RST_BYTE;
      AD_OE <= 1'b0;
      BUF_ADDR <= 14'h3000;
      BUFFER_MEM_SELECT_N <= 1'b1;
      BUF_WRITE_N <= 1'b1;
      HOST_REQ <= 1'b0;
      HOST_DRIVE_ENABLE_N <= 1'b1;
      HOST_RECEIVE_ENABLE_N <= 1'b1;
      DATA_LATCH_STROBE <= 1'b0;
      BUSY_OUT <= 1'b0;
      SEL_OUT <= 1'b0;
      TARGET_EN_N <= 1'b1;
      INITIATOR_EN_N <= 1'b1;
    end else begin
      AD_OUT <= next_rdata;
      AD_OE <= CS & ~RD_N;
      BUFFER_MEM_SELECT_N <= ~(disk_cyc | host_ram | cpu_ram); // see R3
      BUF_WRITE_N <= ~((disk_cyc & dir) | (host_ram & ~dir)
        | (cpu_ram & cpu_wr)); // see R3
      if (max_mode) begin
        // low byte muxed; strobe cycles put the high byte out instead
        BUF_ADDR[7:0] <= strobe_cyc ? (rap_hi_pend ? buffer_read_pointer[15:8] : buffer_write_pointer[15:8])
          : acc_ptr[7:0]; // see R13
        BUF_ADDR[8] <= strobe_cyc & (rap_hi_pend ? dir : ~dir); // see R6
        BUF_ADDR[9] <= strobe_cyc & (rap_hi_pend ? ~dir : dir);
        BUF_ADDR[11:10] <= acc_ptr[11:10];
        BUF_ADDR[12] <= ~acc_host | strobe_cyc | disk_cyc; // see R21
        BUF_ADDR[13] <= ~disk_cyc; // see R21
      end else if (ext) begin
        BUF_ADDR <= acc_ptr[13:0]; // see R12
      end else begin
        BUF_ADDR <= {2'b11, 2'b00, acc_ptr[9:0]}; // see R11, R28
      end
      HOST_REQ <= (hstate == H_REQ) & ~HOST_ACK; // see R26
      HOST_DRIVE_ENABLE_N <= ~(hctrl[`DBSM_HC_BOE] | (arbitrating & ~SEL_IN)
        | (dir & hstate == H_REQ & ~HOST_ACK));
      HOST_RECEIVE_ENABLE_N <= ~(hctrl[`DBSM_HC_BIE]
        | (~dir & (hstate == H_REQ | hstate == H_RAM)));
      DATA_LATCH_STROBE <= (host_ram & dir) | (wr_go
        & (hit(addr, `DBSM_HOST_DATA_LO) | hit(addr, `DBSM_HOST_DATA_HI)));
      BUSY_OUT <= hctrl[`DBSM_HC_BSY] | (arbitrating & ~SEL_IN); // see R8
      SEL_OUT <= hctrl[`DBSM_HC_SEL];
      TARGET_EN_N <= ~hctrl[`DBSM_HC_ET];
      INITIATOR_EN_N <= ~hctrl[`DBSM_HC_EI];
    end
  end
endmodule // dbsm_top
`default_nettype wire

// ---- rtl/dbsm_regs.vh ----
// register offsets, field positions, reset values and timing counts of the
// buffer storage manager; definitions only, included by the top module
`ifndef DBSM_REGS_VH
`define DBSM_REGS_VH
// ============================================================
// register offsets
`define DBSM_HOST_DATA_LO 8'h50
`define DBSM_HOST_DATA_HI 8'h51
`define DBSM_HOST_CTRL 8'h52
`define DBSM_DMA_CTRL 8'h53
`define DBSM_BUF_SIZE 8'h54
`define DBSM_ADDR_MODE 8'h55
`define DBSM_RESET_CTRL 8'h59
`define DBSM_RAP_LO 8'h5A
`define DBSM_RAP_HI 8'h5B
`define DBSM_WAP_LO 8'h5C
`define DBSM_WAP_HI 8'h5D
`define DBSM_STOP_LO 8'h5E
`define DBSM_STOP_HI 8'h5F
`define DBSM_BUF_ACCESS 8'h70
// ============================================================
// field positions
`define DBSM_HC_ARB 0
`define DBSM_HC_EI 1
`define DBSM_HC_BIE 2
`define DBSM_HC_BOE 3
`define DBSM_HC_ET 4
`define DBSM_HC_BSYIN 5
`define DBSM_HC_SEL 6
`define DBSM_HC_BSY 7
`define DBSM_DC_WLATCH 1
`define DBSM_DC_RLATCH 2
`define DBSM_DC_DIR 4
`define DBSM_DC_DONE 5
`define DBSM_AM_EXT 0
`define DBSM_RC_ALL 0
// ============================================================
// reset values and size codes (size = 256 bytes shifted by code)
`define DBSM_RST_BYTE 8'h00
`define DBSM_RST_PTR 16'h0000
`define DBSM_MIN_TOP_CODE 4'h2
`define DBSM_EXT_TOP_CODE 4'h6
`define DBSM_MAX_CODE 4'h8
// ============================================================
// timing counts in primary clock cycles
`define DBSM_FREE_CYCLES 3'h3
`define DBSM_ARB_CYCLES 3'h4
`endif

// ---- testbench/dbsm_checker_sva.sv ----
// checker of the buffer storage manager top ports
// bound to dbsm_top, one clock domain, sees only its ports
`timescale 1ns/100ps
`default_nettype none
module dbsm_checker (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CS,
  input wire logic RD_N,
  input wire logic AD_OE,
  input wire logic DISK_XFER_REQUEST_N,
  input wire logic BUFFER_MEM_SELECT_N,
  input wire logic BUF_WRITE_N,
  input wire logic HOST_REQ,
  input wire logic HOST_ACK,
  input wire logic HOST_DRIVE_ENABLE_N,
  input wire logic DATA_LATCH_STROBE,
  input wire logic BUSY_IN,
  input wire logic SEL_IN,
  input wire logic BUSY_OUT
);
  // ============================================================
  // properties
  // saturating count of idle scsi cycles, too long for a repetition
  logic [3:0] free_cnt;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      free_cnt <= 4'h0;
    end else if (BUSY_IN || SEL_IN) begin
      free_cnt <= 4'h0;
    end else if (free_cnt != 4'hF) begin
      free_cnt <= free_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence s_disk_req; !DISK_XFER_REQUEST_N; endsequence
  sequence s_ram_cycle; !BUFFER_MEM_SELECT_N; endsequence
  sequence s_latch_read; DATA_LATCH_STROBE && !BUFFER_MEM_SELECT_N; endsequence
  property p_disk_answer; s_disk_req |-> ##2 s_ram_cycle; endproperty
  property p_write_sel; !BUF_WRITE_N |-> s_ram_cycle; endproperty
  property p_req_hold; HOST_REQ && !HOST_ACK |=> HOST_REQ; endproperty
  property p_req_drop;
    HOST_REQ && HOST_ACK && !HOST_DRIVE_ENABLE_N |=>
      !HOST_REQ && HOST_DRIVE_ENABLE_N;
  endproperty
  property p_latch_req;
    s_latch_read |=> HOST_REQ && !HOST_DRIVE_ENABLE_N;
  endproperty
  property p_rd_answer; CS && !RD_N |=> AD_OE; endproperty
  property p_rd_release; !(CS && !RD_N) |=> !AD_OE; endproperty
  property p_arb_free; $rose(BUSY_OUT) |-> free_cnt >= 4'h7; endproperty
  property p_sel_abort; SEL_IN |=> !BUSY_OUT; endproperty
  a_disk_answer: assert property (p_disk_answer)
    else $error("disk request not served");
  a_write_sel: assert property (p_write_sel)
    else $error("write strobe without select");
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped before acknowledge");
  a_req_drop: assert property (p_req_drop)
    else $error("request not released after acknowledge");
  a_latch_req: assert property (p_latch_req)
    else $error("no request after buffer read");
  a_rd_answer: assert property (p_rd_answer)
    else $error("register read not answered");
  a_rd_release: assert property (p_rd_release)
    else $error("bus still driven after read");
  a_arb_free: assert property (p_arb_free)
    else $error("arbitration before bus free time");
  a_sel_abort: assert property (p_sel_abort)
    else $error("arbitration kept during select");
endmodule // dbsm_checker
bind dbsm_top dbsm_checker u_dbsm_checker (.CLOCK(CLOCK), .NRST(NRST),
  .CS(CS), .RD_N(RD_N), .AD_OE(AD_OE),
  .DISK_XFER_REQUEST_N(DISK_XFER_REQUEST_N),
  .BUFFER_MEM_SELECT_N(BUFFER_MEM_SELECT_N), .BUF_WRITE_N(BUF_WRITE_N),
  .HOST_REQ(HOST_REQ), .HOST_ACK(HOST_ACK),
  .HOST_DRIVE_ENABLE_N(HOST_DRIVE_ENABLE_N),
  .DATA_LATCH_STROBE(DATA_LATCH_STROBE), .BUSY_IN(BUSY_IN),
  .SEL_IN(SEL_IN), .BUSY_OUT(BUSY_OUT));
`default_nettype wire

// ---- testbench/dbsm_host_model.sv ----
// host side of the req/ack handshake
// assumes host_req registered on the same clock
`timescale 1ns/100ps
`default_nettype none
module dbsm_host_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic host_req,
  input wire logic [1:0] ack_delay,
  output logic host_ack
);
  // ============================================================
  // acknowledge after a chosen delay, held until request drops
  logic [1:0] wait_cnt;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      host_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (!host_req) begin
      host_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == ack_delay) begin
      host_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // dbsm_host_model
`default_nettype wire

// ---- testbench/disk_buffer_storage_manager_tb_top.sv ----
// self-checking bench of the buffer storage manager
// assumes dbsm_top, its checker bind and the host model compiled first
`timescale 1ns/100ps
`include "dbsm_regs.vh"
`default_nettype none
module disk_buffer_storage_manager_tb_top;
  // ============================================================
  // stimulus and checks
  logic clock = 1'b0, nrst = 1'b0, cs = 1'b0, ale = 1'b0;
  logic rd_n = 1'b1, wr_n = 1'b1, disk_n = 1'b1;
  logic busy_in = 1'b0, sel_in = 1'b0, req_q = 1'b0;
  logic [7:0] ad_in = 8'h00, ad_out, rdata;
  logic [1:0] ack_delay = 2'h0;
  logic [13:0] buf_addr;
  logic ad_oe, mem_sel_n, buf_we_n, host_req, host_ack, drive_en_n;
  logic recv_en_n, latch_strobe, busy_out, sel_out, tgt_en_n, init_en_n;
  logic [15:0] p, mk;
  logic [7:0] sz [3] = '{8'h02, 8'h06, 8'h08};
  logic [15:0] bs [3] = '{16'h03FE, 16'h3FFE, 16'h12FE};
  logic [7:0] regs [4] = '{`DBSM_BUF_SIZE, `DBSM_ADDR_MODE, `DBSM_RAP_HI,
    `DBSM_WAP_HI};
  int mismatches = 0, compares = 0, reqs = 0, k;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    req_q <= host_req;
    if (host_req === 1'b1 && req_q === 1'b0) reqs++;
  end
  dbsm_top u_dbsm_top (.CLOCK(clock), .NRST(nrst), .CS(cs), .ALE(ale),
    .RD_N(rd_n), .WR_N(wr_n), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe),
    .DISK_XFER_REQUEST_N(disk_n), .BUF_ADDR(buf_addr),
    .BUFFER_MEM_SELECT_N(mem_sel_n), .BUF_WRITE_N(buf_we_n),
    .HOST_REQ(host_req), .HOST_ACK(host_ack),
    .HOST_DRIVE_ENABLE_N(drive_en_n), .HOST_RECEIVE_ENABLE_N(recv_en_n),
    .DATA_LATCH_STROBE(latch_strobe), .BUSY_IN(busy_in), .SEL_IN(sel_in),
    .BUSY_OUT(busy_out), .SEL_OUT(sel_out), .TARGET_EN_N(tgt_en_n),
    .INITIATOR_EN_N(init_en_n));
  dbsm_host_model u_dbsm_host_model (.clock(clock), .nrst(nrst),
    .host_req(host_req), .ack_delay(ack_delay), .host_ack(host_ack));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    ale <= 1'b1;
    ad_in <= a;
    @(posedge clock);
    ale <= 1'b0;
    cs <= 1'b1;
    wr_n <= 1'b0;
    ad_in <= d;
    @(posedge clock);
    cs <= 1'b0;
    wr_n <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    ale <= 1'b1;
    ad_in <= a;
    @(posedge clock);
    ale <= 1'b0;
    cs <= 1'b1;
    rd_n <= 1'b0;
    repeat (2) @(posedge clock);
    rdata = ad_out;
    cs <= 1'b0;
    rd_n <= 1'b1;
  endtask
  // one request per two clocks at most, ends on the edge that closes the ram cycle, so checks still see it
  task automatic disk_cycle;
    @(posedge clock);
    disk_n <= 1'b0;
    @(posedge clock);
    disk_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  function automatic logic [13:0] exp_addr(input int m, input logic [15:0] a);
    if (m == 0) return {4'hC, a[9:0]};
    if (m == 1) return a[13:0];
    return {2'b01, a[11:10], 2'b00, a[7:0]};
  endfunction
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    complete_run;
  end
  initial begin
    void'($urandom(74));
    repeat (16) @(posedge clock);
    chk(buf_addr, 14'h3000);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(rdata, 8'h00);
    end
    rd(`DBSM_HOST_DATA_LO);
    chk(rdata, 8'h00);
    foreach (regs[i]) begin
      p = $urandom;
      wr(regs[i], p[7:0]);
      rd(regs[i]);
      chk(rdata, p[7:0]);
    end
    wr(8'h56, 8'hA5);
    rd(8'h56);
    chk(rdata, 8'h00);
    // sizes at each mode's top plus wrap and a 256 byte crossing
    for (int m = 0; m < 3; m++) begin
      for (int dir = 0; dir < 2; dir++) begin
        wr(`DBSM_BUF_SIZE, sz[m]);
        wr(`DBSM_ADDR_MODE, {7'h00, m == 1});
        p = bs[m];
        mk = (16'h0100 << sz[m]) - 16'h0001;
        wr(dir ? `DBSM_WAP_LO : `DBSM_RAP_LO, p[7:0]);
        wr(dir ? `DBSM_WAP_HI : `DBSM_RAP_HI, p[15:8]);
        wr(`DBSM_DMA_CTRL, dir ? 8'h10 : 8'h00);
        repeat (4) @(posedge clock);
        repeat (3) begin
          disk_cycle;
          chk(buf_addr, exp_addr(m, p));
          chk({mem_sel_n, buf_we_n}, {1'b0, dir == 0});
          p = (p & ~mk) | ((p + 16'h0001) & mk);
          if (m == 2 && p[7:0] == 8'h00) begin
            @(posedge clock);
            chk({buf_addr[9], buf_addr[7:0]}, {1'b1, p[15:8]});
          end
        end
        rd(dir ? `DBSM_WAP_LO : `DBSM_RAP_LO);
        chk(rdata, p[7:0]);
      end
    end
    // host read dma with disk writes competing for the ram
    wr(`DBSM_RESET_CTRL, 8'h01);
    wr(`DBSM_BUF_SIZE, 8'h02);
    p = {6'h00, 10'($urandom)};
    wr(`DBSM_WAP_LO, p[7:0]);
    wr(`DBSM_WAP_HI, p[15:8]);
    wr(`DBSM_STOP_LO, 8'h03);
    ack_delay <= 2'($urandom);
    reqs = 0;
    wr(`DBSM_DMA_CTRL, 8'h14);
    repeat (3) begin
      disk_cycle;
      chk({buf_addr, buf_we_n}, {exp_addr(0, p), 1'b0});
      p = p + 16'h0001;
    end
    k = 0;
    while (reqs < 3 && k < 200) begin
      @(posedge clock);
      k++;
    end
    repeat (20) @(posedge clock);
    chk(16'(reqs), 16'h0003);
    rd(`DBSM_DMA_CTRL);
    chk(rdata, 8'h34);
    rd(`DBSM_RAP_LO);
    chk(rdata, 8'h03);
    // host write dma after a pointer-only reset
    wr(`DBSM_RESET_CTRL, 8'h00);
    wr(`DBSM_STOP_LO, 8'h02);
    reqs = 0;
    wr(`DBSM_DMA_CTRL, 8'h02);
    repeat (40) @(posedge clock);
    chk(16'(reqs), 16'h0002);
    rd(`DBSM_WAP_LO);
    chk(rdata, 8'h02);
    rd(`DBSM_DMA_CTRL);
    chk(rdata, 8'h22);
    // cpu buffer write through the logical register, read pointer used
    wr(`DBSM_BUF_ACCESS, 8'h5A);
    repeat (2) @(posedge clock);
    chk({mem_sel_n, buf_we_n, buf_addr}, {2'b00, 14'h3000});
    // host control bits straight to their pins
    wr(`DBSM_HOST_CTRL, 8'h56);
    repeat (2) @(posedge clock);
    chk({sel_out, tgt_en_n, init_en_n, recv_en_n}, 4'h8);
    // arbitration request held while busy, then run after bus free
    @(posedge clock);
    busy_in <= 1'b1;
    wr(`DBSM_HOST_CTRL, 8'h01);
    repeat (12) @(posedge clock);
    chk(busy_out, 1'b0);
    busy_in <= 1'b0;
    repeat (6) @(posedge clock);
    chk(busy_out, 1'b0);
    repeat (4) @(posedge clock);
    chk({busy_out, drive_en_n}, 2'b10);
    rd(`DBSM_HOST_CTRL);
    chk(rdata[0], 1'b1);
    sel_in <= 1'b1;
    repeat (2) @(posedge clock);
    chk(busy_out, 1'b0);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    chk({buf_addr, busy_out}, {14'h3000, 1'b0});
    complete_run;
  end
endmodule // disk_buffer_storage_manager_tb_top
`default_nettype wire
